// ### logic/ee_pkg.sv
package ee_pkg;

    // Array geometry
    localparam int ADDR_W     = 10;
    localparam int DATA_W     = 8;
    localparam int OFS_W      = 4;
    localparam int PAGE_W     = ADDR_W - OFS_W;
    localparam int PAGE_BYTES = 16;
    localparam int CNT_W      = 17;

    // Wishbone byte offsets
    localparam logic [7:0] OFS_ADDR_LOW  = 8'h00;
    localparam logic [7:0] OFS_ADDR_HIGH = 8'h04;
    localparam logic [7:0] OFS_DATA      = 8'h08;
    localparam logic [7:0] OFS_CTRL      = 8'h0C;
    localparam logic [7:0] OFS_STATUS    = 8'h10;

    // Control register fields
    localparam int CTL_TIME_SEL = 7;
    localparam int CTL_ERASE_EN = 6;
    localparam int CTL_ERASE_GO = 5;
    localparam int CTL_MODE     = 4;
    localparam int CTL_WRITE_EN = 3;
    localparam int CTL_WRITE_GO = 2;
    localparam int CTL_READ_EN  = 1;
    localparam int CTL_READ_GO  = 0;

    // Status register fields
    localparam int ST_BUSY     = 0;
    localparam int ST_PAGE_END = 1;

    // Reset values and last page offset
    localparam logic [7:0] RST_ADDR_LOW  = 8'h00;
    localparam logic [1:0] RST_ADDR_HIGH = 2'h0;
    localparam logic [7:0] RST_DATA      = 8'h00;
    localparam logic [7:0] RST_CTRL      = 8'h00;
    localparam logic [3:0] OFS_LAST      = 4'hF;

    // Timing
    localparam real CLK_HZ        = 20.0e6;
    localparam real ERASE_T0_MS   = 3.2;
    localparam real ERASE_T1_MS   = 3.7;
    localparam real WRITE_T0_MS   = 2.2;
    localparam real WRITE_T1_MS   = 3.0;
    localparam int  ERASE_T0_CYC  = int'($ceil(ERASE_T0_MS * CLK_HZ / 1000.0 - 1.0e-6));
    localparam int  ERASE_T1_CYC  = int'($ceil(ERASE_T1_MS * CLK_HZ / 1000.0 - 1.0e-6));
    localparam int  WRITE_T0_CYC  = int'($ceil(WRITE_T0_MS * CLK_HZ / 1000.0 - 1.0e-6));
    localparam int  WRITE_T1_CYC  = int'($ceil(WRITE_T1_MS * CLK_HZ / 1000.0 - 1.0e-6));
    localparam logic [1:0] READ_WAIT = 2'h1;

    typedef enum logic [1:0] {
        S_IDLE   = 2'b00,
        S_READ   = 2'b01,
        S_TIME   = 2'b11,
        S_COMMIT = 2'b10
    } state_t;

    typedef struct packed {
        logic              en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } mem_wr_t;

endpackage : ee_pkg

// ### logic/ee_array.sv
`timescale 1ns/1ps
module ee_array #(
    parameter int AW = ee_pkg::ADDR_W,
    parameter int DW = ee_pkg::DATA_W
) (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            resetn,
    // Write port
    input  wire ee_pkg::mem_wr_t wr,
    // Read port
    input  wire logic [AW-1:0]   rd_addr,
    output logic      [DW-1:0]   rd_data
);

    logic [DW-1:0] cells [(1<<AW)];

    always_ff @(posedge clk) begin
        if (wr.en) begin
            cells[wr.addr] <= wr.data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_data <= '0;
        end else begin
            rd_data <= cells[rd_addr];
        end
    end

endmodule : ee_array

// ### logic/ee_timer.sv
`timescale 1ns/1ps
module ee_timer #(
    parameter int W = ee_pkg::CNT_W
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    // Control
    input  wire logic         start,
    input  wire logic [W-1:0] load,
    // Status
    output logic              running,
    output logic              done
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         run;
        logic         done;
    } tmr_t;

    tmr_t s_q;
    tmr_t s_d;

    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        if (start) begin
            s_d.cnt = load;
            s_d.run = 1'b1;
        end else if (s_q.run) begin
            s_d.cnt = s_q.cnt - W'(1);
            if (s_q.cnt <= W'(1)) begin
                s_d.run  = 1'b0;
                s_d.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign running = s_q.run;
    assign done    = s_q.done;

endmodule : ee_timer

// ### logic/ee_access_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: erase lasts 3.2 ms or 3.7 ms
// RULE2: write lasts 2.2 ms or 3.0 ms
// RULE3: erase needs erase enable, cleared after erase
// RULE4: erase go starts erase, self-clears at end
// RULE5: mode bit picks byte or 16-byte page
// RULE6: write needs write enable, cleared after write
// RULE7: write go starts write, self-clears at end
// RULE8: reads need read enable; clearing inhibits
// RULE9: read go starts read, self-clears when done
// RULE10: software sets one enable/go bit per write
// RULE11: software ensures sub clock stable first
// RULE12: software waits for completion before changes
// RULE13: byte read fetches addressed byte into data
// RULE14: read byte held until next read/write
// RULE15: page read clears go, bumps address
// RULE16: upper six bits page, lower four offset
// RULE17: offset stops at 0FH, never wraps
// RULE18: 1K x 8 array, ten-bit address
// RULE19: erased page bytes read as zero
// RULE20: fixed read latency, completion pulse after erase/write
module ee_access_ctrl #(
    parameter int ERASE_T0_CYC = ee_pkg::ERASE_T0_CYC,
    parameter int ERASE_T1_CYC = ee_pkg::ERASE_T1_CYC,
    parameter int WRITE_T0_CYC = ee_pkg::WRITE_T0_CYC,
    parameter int WRITE_T1_CYC = ee_pkg::WRITE_T1_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Wishbone classic slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Status
    output logic             busy,
    output logic             done_pulse
);

    localparam int AW = ee_pkg::ADDR_W;
    localparam int DW = ee_pkg::DATA_W;
    localparam int OW = ee_pkg::OFS_W;
    localparam int NB = ee_pkg::PAGE_BYTES;

    typedef struct packed {
        ee_pkg::state_t        st;
        logic [7:0]            addr_low;
        logic [1:0]            addr_high;
        logic [DW-1:0]         data;
        logic                  time_sel;
        logic                  erase_en;
        logic                  erase_go;
        logic                  mode;
        logic                  write_en;
        logic                  write_go;
        logic                  read_en;
        logic                  read_go;
        logic                  op_erase;
        logic                  page_end;
        logic [NB-1:0][DW-1:0] pbuf;
        logic [NB-1:0]         tag;
        logic [OW-1:0]         idx;
        logic [1:0]            rwait;
        logic                  ack;
        logic [31:0]           rdata;
        logic                  done;
    } ctl_t;

    ctl_t s_q;
    ctl_t s_d;

    ee_pkg::mem_wr_t     mem_wr;
    logic [AW-1:0]       rd_addr;
    logic [DW-1:0]       rd_data;
    logic                t_start;
    logic [ee_pkg::CNT_W-1:0] t_load;
    logic                t_run;
    logic                t_done;
    logic                req;
    logic                wr_now;

    // Saturating offset step inside one page
    function automatic logic [7:0] next_low(input logic [7:0] low);
        next_low = (low[OW-1:0] == ee_pkg::OFS_LAST) ? low : low + 8'h01; // [RULE16] [RULE17]
    endfunction : next_low

    // Cycle length for the operation and time select
    function automatic logic [ee_pkg::CNT_W-1:0] cycle_len(input logic erase, input logic slow);
        unique case ({erase, slow})
            2'b00: cycle_len = ee_pkg::CNT_W'(WRITE_T0_CYC); // [RULE2]
            2'b01: cycle_len = ee_pkg::CNT_W'(WRITE_T1_CYC); // [RULE2]
            2'b10: cycle_len = ee_pkg::CNT_W'(ERASE_T0_CYC); // [RULE1]
            2'b11: cycle_len = ee_pkg::CNT_W'(ERASE_T1_CYC); // [RULE1]
        endcase
    endfunction : cycle_len

    function automatic logic [7:0] ctrl_byte(input ctl_t c);
        ctrl_byte = '0;
        ctrl_byte[ee_pkg::CTL_TIME_SEL] = c.time_sel;
        ctrl_byte[ee_pkg::CTL_ERASE_EN] = c.erase_en;
        ctrl_byte[ee_pkg::CTL_ERASE_GO] = c.erase_go;
        ctrl_byte[ee_pkg::CTL_MODE]     = c.mode;
        ctrl_byte[ee_pkg::CTL_WRITE_EN] = c.write_en;
        ctrl_byte[ee_pkg::CTL_WRITE_GO] = c.write_go;
        ctrl_byte[ee_pkg::CTL_READ_EN]  = c.read_en;
        ctrl_byte[ee_pkg::CTL_READ_GO]  = c.read_go;
    endfunction : ctrl_byte

    assign req    = cyc_i & stb_i;
    assign wr_now = req & s_q.ack & we_i & sel_i[0];
    assign rd_addr = {s_q.addr_high, s_q.addr_low}; // [RULE18]

    always_comb begin
        s_d         = s_q;
        s_d.done    = 1'b0;
        s_d.ack     = req & ~s_q.ack;
        t_start     = 1'b0;
        t_load      = '0;
        mem_wr      = '0;

        // Read data captured as ack rises
        if (req & ~s_q.ack) begin
            unique case (adr_i)
                ee_pkg::OFS_ADDR_LOW:  s_d.rdata = {24'h000000, s_q.addr_low};
                ee_pkg::OFS_ADDR_HIGH: s_d.rdata = {30'h00000000, s_q.addr_high};
                ee_pkg::OFS_DATA:      s_d.rdata = {24'h000000, s_q.data};
                ee_pkg::OFS_CTRL:      s_d.rdata = {24'h000000, ctrl_byte(s_q)};
                ee_pkg::OFS_STATUS: begin
                    s_d.rdata = '0;
                    s_d.rdata[ee_pkg::ST_BUSY]     = (s_q.st != ee_pkg::S_IDLE);
                    s_d.rdata[ee_pkg::ST_PAGE_END] = s_q.page_end;
                end
                default:               s_d.rdata = '0;
            endcase
        end

        // Register writes take effect at the acknowledged edge
        if (wr_now) begin
            unique case (adr_i)
                ee_pkg::OFS_ADDR_LOW: begin
                    s_d.addr_low = dat_i[7:0];
                    s_d.page_end = 1'b0;
                end
                ee_pkg::OFS_ADDR_HIGH: s_d.addr_high = dat_i[1:0];
                ee_pkg::OFS_DATA: begin
                    if (!s_q.mode) begin
                        s_d.data = dat_i[DW-1:0];
                    end else if (!s_q.page_end && s_q.st == ee_pkg::S_IDLE) begin
                        // Page load: fill buffer, tag byte, step offset
                        s_d.data = dat_i[DW-1:0];
                        s_d.pbuf[s_q.addr_low[OW-1:0]] = dat_i[DW-1:0];
                        s_d.tag[s_q.addr_low[OW-1:0]]  = 1'b1;
                        s_d.addr_low = next_low(s_q.addr_low); // [RULE17]
                        s_d.page_end = (s_q.addr_low[OW-1:0] == ee_pkg::OFS_LAST);
                    end
                end
                ee_pkg::OFS_CTRL: begin
                    s_d.time_sel = dat_i[ee_pkg::CTL_TIME_SEL];
                    s_d.mode     = dat_i[ee_pkg::CTL_MODE];                   // [RULE5]
                    s_d.erase_en = dat_i[ee_pkg::CTL_ERASE_EN];
                    s_d.write_en = dat_i[ee_pkg::CTL_WRITE_EN];
                    s_d.read_en  = dat_i[ee_pkg::CTL_READ_EN];
                    if (s_q.st == ee_pkg::S_IDLE) begin
                        // Go bits only act with their enable already set
                        if (dat_i[ee_pkg::CTL_ERASE_GO] && s_q.erase_en) begin // [RULE3] [RULE4]
                            s_d.erase_go = 1'b1;
                            s_d.op_erase = 1'b1;
                            s_d.st       = ee_pkg::S_TIME;
                            t_start      = 1'b1;
                            t_load       = cycle_len(1'b1, s_q.time_sel);         // [RULE1]
                        end else if (dat_i[ee_pkg::CTL_WRITE_GO] && s_q.write_en) begin // [RULE6] [RULE7]
                            s_d.write_go = 1'b1;
                            s_d.op_erase = 1'b0;
                            s_d.st       = ee_pkg::S_TIME;
                            t_start      = 1'b1;
                            t_load       = cycle_len(1'b0, s_q.time_sel);         // [RULE2]
                        end else if (dat_i[ee_pkg::CTL_READ_GO] && s_q.read_en) begin // [RULE8] [RULE9]
                            s_d.read_go = 1'b1;
                            s_d.rwait   = ee_pkg::READ_WAIT;
                            s_d.st      = ee_pkg::S_READ;
                        end
                    end
                end
                default: ;
            endcase
        end

        unique case (s_q.st)
            ee_pkg::S_IDLE: ;
            ee_pkg::S_READ: begin
                if (!s_d.read_en) begin
                    // Read enable dropped: abandon without touching data
                    s_d.read_go = 1'b0;                                         // [RULE8]
                    s_d.st      = ee_pkg::S_IDLE;
                end else if (s_q.rwait != 2'h0) begin
                    s_d.rwait = s_q.rwait - 2'h1;                               // [RULE20]
                end else begin
                    s_d.data    = rd_data;                                      // [RULE13] [RULE14]
                    s_d.read_go = 1'b0;                                         // [RULE9]
                    s_d.st      = ee_pkg::S_IDLE;
                    if (s_q.mode) begin
                        s_d.addr_low = next_low(s_q.addr_low);                  // [RULE15] [RULE16]
                    end
                end
            end
            ee_pkg::S_TIME: begin
                if (s_q.op_erase ? !s_d.erase_en : !s_d.write_en) begin
                    // Enable withdrawn mid-cycle: cells left untouched
                    s_d.erase_go = 1'b0;                                        // [RULE3]
                    s_d.write_go = 1'b0;                                        // [RULE6]
                    s_d.st       = ee_pkg::S_IDLE;
                end else if (t_done) begin
                    s_d.idx = '0;
                    s_d.st  = ee_pkg::S_COMMIT;
                end
            end
            ee_pkg::S_COMMIT: begin
                if (!s_q.mode) begin
                    // Byte mode: one cell, erase leaves zero
                    mem_wr.en   = 1'b1;
                    mem_wr.addr = rd_addr;
                    mem_wr.data = s_q.op_erase ? '0 : s_q.data;                 // [RULE19]
                end else begin
                    // Page mode: walk the tagged offsets of the page
                    mem_wr.en   = s_q.tag[s_q.idx];
                    mem_wr.addr = {s_q.addr_high, s_q.addr_low[7:OW], s_q.idx}; // [RULE16]
                    mem_wr.data = s_q.op_erase ? '0 : s_q.pbuf[s_q.idx];        // [RULE19]
                end
                s_d.idx = s_q.idx + OW'(1);
                if (!s_q.mode || s_q.idx == ee_pkg::OFS_LAST) begin
                    s_d.st   = ee_pkg::S_IDLE;
                    s_d.done = 1'b1;                                            // [RULE20]
                    if (s_q.op_erase) begin
                        s_d.erase_go = 1'b0;                                    // [RULE4]
                        s_d.erase_en = 1'b0;                                    // [RULE3]
                    end else begin
                        s_d.write_go = 1'b0;                                    // [RULE7]
                        s_d.write_en = 1'b0;                                    // [RULE6]
                    end
                end
            end
        endcase

        // Dropping either enable empties the page buffer
        if ((s_q.erase_en && !s_d.erase_en) || (s_q.write_en && !s_d.write_en)) begin
            s_d.pbuf     = '0;
            s_d.tag      = '0;
            s_d.page_end = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q           <= '0;
            s_q.st        <= ee_pkg::S_IDLE;
            s_q.addr_low  <= ee_pkg::RST_ADDR_LOW;
            s_q.addr_high <= ee_pkg::RST_ADDR_HIGH;
            s_q.data      <= ee_pkg::RST_DATA;
            s_q.time_sel  <= ee_pkg::RST_CTRL[ee_pkg::CTL_TIME_SEL];
            s_q.erase_en  <= ee_pkg::RST_CTRL[ee_pkg::CTL_ERASE_EN];
            s_q.erase_go  <= ee_pkg::RST_CTRL[ee_pkg::CTL_ERASE_GO];
            s_q.mode      <= ee_pkg::RST_CTRL[ee_pkg::CTL_MODE];
            s_q.write_en  <= ee_pkg::RST_CTRL[ee_pkg::CTL_WRITE_EN];
            s_q.write_go  <= ee_pkg::RST_CTRL[ee_pkg::CTL_WRITE_GO];
            s_q.read_en   <= ee_pkg::RST_CTRL[ee_pkg::CTL_READ_EN];
            s_q.read_go   <= ee_pkg::RST_CTRL[ee_pkg::CTL_READ_GO];
        end else begin
            s_q <= s_d;
        end
    end

    ee_timer #(
        .W (ee_pkg::CNT_W)
    ) u_timer (
        .clk     (clk),
        .resetn  (resetn),
        .start   (t_start),
        .load    (t_load),
        .running (t_run),
        .done    (t_done)
    );

    ee_array #(
        .AW (AW),
        .DW (DW)
    ) u_array (
        .clk     (clk),
        .resetn  (resetn),
        .wr      (mem_wr),
        .rd_addr (rd_addr),
        .rd_data (rd_data)
    );

    assign dat_o      = s_q.rdata;
    assign ack_o      = s_q.ack;
    assign busy       = (s_q.st != ee_pkg::S_IDLE) | t_run;
    assign done_pulse = s_q.done;

endmodule : ee_access_ctrl

// ### bench/ee_access_ctrl_properties.sv
`timescale 1ns/1ps
module ee_access_ctrl_properties #(
    parameter int ERASE_T0_CYC = 20,
    parameter int ERASE_T1_CYC = 24,
    parameter int WRITE_T0_CYC = 10,
    parameter int WRITE_T1_CYC = 14
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        resetn,
    // Wishbone
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // Status
    input wire logic        busy,
    input wire logic        done_pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Length of the latest busy run
    logic busy_q;
    int   run_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy_q <= 1'b0;
            run_q  <= 0;
        end else begin
            busy_q <= busy;
            if (busy && !busy_q) run_q <= 1;
            else if (busy) run_q <= run_q + 1;
        end
    end

    AST_ACK_NEXT: assert property ($rose(cyc_i && stb_i) |=> ack_o) else $error("ack late");
    AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
    AST_UNMAPPED: assert property (ack_o && !we_i && !(adr_i inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10})
        |-> dat_o == 32'h0) else $error("unmapped read not zero");
    AST_UPPER_ZERO: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper read bits set");
    AST_HIGH_BITS: assert property (ack_o && !we_i && adr_i == ee_pkg::OFS_ADDR_HIGH |-> dat_o[7:2] == 6'h0)
        else $error("address high spare bits set");
    AST_DONE_PULSE: assert property (done_pulse |=> !done_pulse) else $error("done too long");
    AST_DONE_MIN: assert property (done_pulse |-> run_q >= WRITE_T0_CYC) else $error("cycle too short");
    AST_DONE_MAX: assert property (done_pulse |-> run_q <= ERASE_T1_CYC + 24) else $error("cycle too long");
endmodule : ee_access_ctrl_properties

bind ee_access_ctrl ee_access_ctrl_properties #(
    .ERASE_T0_CYC(ERASE_T0_CYC), .ERASE_T1_CYC(ERASE_T1_CYC),
    .WRITE_T0_CYC(WRITE_T0_CYC), .WRITE_T1_CYC(WRITE_T1_CYC)
) checker_i (
    .clk(clk), .resetn(resetn), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .busy(busy), .done_pulse(done_pulse)
);

// ### bench/ee_host.sv
`timescale 1ns/1ps
module ee_host (
    // Clock
    input wire logic        clk,
    // Wishbone master
    output logic            cyc,
    output logic            stb,
    output logic            we,
    output logic [7:0]      adr,
    output logic [3:0]      sel,
    output logic [31:0]     wdat,
    input wire logic [31:0] rdat,
    input wire logic        ack
);
    initial begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        wdat = 32'h0;
    end

    // Idle edge first keeps requests apart
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        wdat <= {24'h0, d};
        do @(posedge clk); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        xfer(1'b0, a, 8'h00, r);
    endtask : rd

    // No register change until the go bit drops
    task automatic poll(input logic [7:0] m);
        logic [31:0] r;
        r = 32'hFF;
        while ((r[7:0] & m) != 8'h00) rd(ee_pkg::OFS_CTRL, r);
    endtask : poll
endmodule : ee_host

// ### bench/tb_ee_access_ctrl.sv
`timescale 1ns/1ps
module tb_ee_access_ctrl;
    localparam int ET0 = 200;
    localparam int ET1 = 240;
    localparam int WT0 = 100;
    localparam int WT1 = 140;
    localparam logic [7:0] LO = ee_pkg::OFS_ADDR_LOW;
    localparam logic [7:0] HI = ee_pkg::OFS_ADDR_HIGH;
    localparam logic [7:0] DA = ee_pkg::OFS_DATA;
    localparam logic [7:0] CT = ee_pkg::OFS_CTRL;

    logic        clk, resetn, cyc, stb, we, ack, busy, done_pulse;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, seed;
    int          miscompares, compares, dones;
    logic [7:0]  img [16];
    logic [9:0]  a;

    ee_access_ctrl #(.ERASE_T0_CYC(ET0), .ERASE_T1_CYC(ET1), .WRITE_T0_CYC(WT0), .WRITE_T1_CYC(WT1))
    ee_access_ctrl_i (.clk(clk), .resetn(resetn), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .busy(busy), .done_pulse(done_pulse));
    ee_host ee_host_i (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .wdat(wdat),
        .rdat(rdat), .ack(ack));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
    endfunction : lfsr_next

    // Page offset after n steps from zero, held at the page end
    function automatic logic [3:0] exp_ofs(input int n);
        return (n > 15) ? 4'hF : 4'(n);
    endfunction : exp_ofs

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic rc(input logic [7:0] ad, input logic [31:0] exp);
        logic [31:0] r;
        ee_host_i.rd(ad, r);
        chk(r, exp);
    endtask : rc

    // Enable, then go, then time the cycle
    task automatic op(input logic ts, input logic md, input int en, input int go, input int t);
        logic [7:0] b;
        int n0;
        time t0;
        b = {ts, 2'b00, md, 4'h0};
        n0 = dones;
        ee_host_i.wr(CT, b | (8'h01 << en));
        ee_host_i.wr(CT, b | (8'h01 << en) | (8'h01 << go));
        t0 = $time;
        rc(ee_pkg::OFS_STATUS, {30'h0, md, 1'b1});
        ee_host_i.poll(8'h01 << go);
        chk(32'(($time - t0) / 50 >= t && ($time - t0) / 50 <= t + 24), 32'h1);
        rc(CT, {24'h0, b});
        chk(32'(dones), 32'(n0 + 1));
    endtask : op

    task automatic byte_read(input logic [7:0] d);
        ee_host_i.wr(DA, ~d);
        ee_host_i.wr(CT, 8'h02);
        ee_host_i.wr(CT, 8'h03);
        ee_host_i.poll(8'h01);
        rc(DA, {24'h0, d});
        ee_host_i.wr(CT, 8'h00);
        rc(DA, {24'h0, d});
    endtask : byte_read

    task automatic page_fill(input logic ers);
        ee_host_i.wr(CT, 8'h10);
        ee_host_i.wr(LO, {a[7:4], 4'h0});
        for (int i = 0; i < 18; i++) begin
            seed = lfsr_next(seed);
            if (i < 16) img[i] = ers ? 8'h00 : seed[7:0];
            ee_host_i.wr(DA, seed[7:0]);
        end
        rc(LO, {24'h0, a[7:4], exp_ofs(18)});
        rc(ee_pkg::OFS_STATUS, 32'h2);
    endtask : page_fill

    task automatic page_read();
        ee_host_i.wr(LO, {a[7:4], 4'h0});
        ee_host_i.wr(CT, 8'h12);
        for (int i = 0; i < 17; i++) begin
            ee_host_i.wr(CT, 8'h13);
            ee_host_i.poll(8'h01);
            rc(DA, {24'h0, img[exp_ofs(i)]});
            rc(LO, {24'h0, a[7:4], exp_ofs(i + 1)});
        end
    endtask : page_read

    task automatic test_done();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) if (done_pulse === 1'b1) dones <= dones + 1;

    initial begin
        #(50 * 40000);
        miscompares++;
        test_done();
    end

    initial begin
        miscompares = 0;
        compares = 0;
        seed = 32'h08B9;
        resetn = 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        for (int k = 0; k < 6; k++) rc(8'(k * 4), 32'h0);
        ee_host_i.wr(8'h14, 8'hFF);
        rc(8'h14, 32'h0);
        for (int j = 0; j < 3; j++) begin
            ee_host_i.wr(CT, 8'h01 << (j * 2 + int'(j == 2)));
            rc(CT, 32'h0);
            chk({31'h0, busy}, 32'h0);
        end
        for (int i = 0; i < 6; i++) begin
            seed = lfsr_next(seed);
            a = seed[9:0];
            ee_host_i.wr(LO, a[7:0]);
            ee_host_i.wr(HI, {6'h0, a[9:8]});
            ee_host_i.wr(DA, seed[17:10]);
            op(i[0], 1'b0, ee_pkg::CTL_WRITE_EN, ee_pkg::CTL_WRITE_GO, i[0] ? WT1 : WT0);
            byte_read(seed[17:10]);
            op(i[0], 1'b0, ee_pkg::CTL_ERASE_EN, ee_pkg::CTL_ERASE_GO, i[0] ? ET1 : ET0);
            byte_read(8'h00);
        end
        page_fill(1'b0);
        op(1'b0, 1'b1, ee_pkg::CTL_WRITE_EN, ee_pkg::CTL_WRITE_GO, WT0);
        page_read();
        page_fill(1'b1);
        op(1'b1, 1'b1, ee_pkg::CTL_ERASE_EN, ee_pkg::CTL_ERASE_GO, ET1);
        page_read();
        test_done();
    end
endmodule : tb_ee_access_ctrl
